//--- qrm_pkg.sv
// qrm_pkg: constants shared by the resource monitor register block
// assumes: one 40 MHz clock, 32-bit register address, 64-bit register data
package qrm_pkg;
   // ----------------------------------------------------------------
   // bus widths
   // ----------------------------------------------------------------
   localparam int unsigned ADDR_W     = 32;
   localparam int unsigned DATA_W     = 64;
   localparam int unsigned OP_BYTES_W = 8;

   // ----------------------------------------------------------------
   // identifier space: largest identifier 3, so N = log2(3 + 1)
   // ----------------------------------------------------------------
   localparam int unsigned RESOURCE_MONITOR_IDENTIFIER_MAX = 3;
   localparam int unsigned RESOURCE_MONITOR_IDENTIFIER_W   = $clog2(RESOURCE_MONITOR_IDENTIFIER_MAX + 1);
   localparam int unsigned RESOURCE_MONITOR_IDENTIFIER_CNT = RESOURCE_MONITOR_IDENTIFIER_MAX + 1;

   // ----------------------------------------------------------------
   // register addresses
   // ----------------------------------------------------------------
   localparam logic [ADDR_W-1:0] ADDR_EVT_SEL  = 32'h0000_0C8D;
   localparam logic [ADDR_W-1:0] ADDR_CTR      = 32'h0000_0C8E;
   localparam logic [ADDR_W-1:0] ADDR_ASSOC    = 32'h0000_0C8F;
   localparam logic [ADDR_W-1:0] ADDR_IRQ_STAT = 32'h0000_0C98;
   localparam logic [ADDR_W-1:0] ADDR_IRQ_CLR  = 32'h0000_0C99;
   localparam logic [ADDR_W-1:0] ADDR_IRQ_EN   = 32'h0000_0C9A;
   localparam logic [ADDR_W-1:0] RSVD_LO       = 32'h4000_0000;
   localparam logic [ADDR_W-1:0] RSVD_HI       = 32'h4000_00FF;

   // ----------------------------------------------------------------
   // field layout
   // ----------------------------------------------------------------
   localparam int unsigned EVT_LSB    = 0;
   localparam int unsigned EVT_W      = 8;
   localparam int unsigned RESOURCE_MONITOR_IDENTIFIER_LSB   = 32;
   localparam int unsigned CTR_DATA_W = 62;
   localparam int unsigned CTR_UNAV   = 62;
   localparam int unsigned CTR_ERR    = 63;
   localparam logic [CTR_DATA_W-1:0] CTR_ONE = 62'h1;

   // ----------------------------------------------------------------
   // monitor_event_code values: the two supported codes and the reset value
   // ----------------------------------------------------------------
   localparam logic [EVT_W-1:0] EVT_OP_COUNT   = 8'h01;
   localparam logic [EVT_W-1:0] EVT_BYTE_COUNT = 8'h02;
   localparam logic [EVT_W-1:0] EVT_RESET      = 8'h00;

   // ----------------------------------------------------------------
   // interrupt status bits
   // ----------------------------------------------------------------
   localparam int unsigned IRQ_W       = 3;
   localparam int unsigned IRQ_SEL_ERR = 0;
   localparam int unsigned IRQ_RSVD    = 1;
   localparam int unsigned IRQ_UNMAP   = 2;
endpackage

//--- qrm_monitor.sv
// qrm_monitor: resource monitor registers, counters and interrupt
// assumes: single clock i_mclk, synchronous reset, plain register port
// Contract
// R1: select, counter and association registers exist only while the capability strap is set.
// R2: select bits 7:0 name the monitor event whose value the counter reports.
// R3: select bits N+31:32 name the resource identifier whose data the counter reports.
// R4: counter bits 61:0 give the data and bit 62 flags data unavailable or unmonitored.
// R5: counter bit 63 flags that an unsupported identifier or event was written to select.
// R6: association bits N-1:0 tag internal operations with an identifier, upper bits reserved.
// R7: no register answers anywhere in 0x40000000 through 0x400000FF.
// R8: a counter read right after a select write already reflects the new selection.
`timescale 1ns/1ps
`default_nettype none
module qrm_monitor (
   input  wire logic                            i_mclk,
   input  wire logic                            i_reset,
   input  wire logic                            i_cap_strap,
   input  wire logic [qrm_pkg::ADDR_W-1:0]      i_addr,
   input  wire logic [qrm_pkg::DATA_W-1:0]      i_wdata,
   input  wire logic                            i_wr,
   input  wire logic                            i_rd,
   input  wire logic                            i_op_valid,
   input  wire logic [qrm_pkg::OP_BYTES_W-1:0]  i_op_bytes,
   output logic      [qrm_pkg::DATA_W-1:0]      o_rdata,
   output logic      [qrm_pkg::RESOURCE_MONITOR_IDENTIFIER_W-1:0]      o_op_resource_monitor_identifier,
   output logic                                 o_irq
);
   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   logic                              cap_meta_ff;
   logic                              cap_ff;
   logic [qrm_pkg::EVT_W-1:0]         sel_evt_ff;
   logic [qrm_pkg::RESOURCE_MONITOR_IDENTIFIER_W-1:0]        sel_resource_monitor_identifier_ff;
   logic                              sel_err_ff;
   logic [qrm_pkg::RESOURCE_MONITOR_IDENTIFIER_W-1:0]        assoc_ff;
   logic [qrm_pkg::CTR_DATA_W-1:0]    op_cnt_ff   [qrm_pkg::RESOURCE_MONITOR_IDENTIFIER_CNT];
   logic [qrm_pkg::CTR_DATA_W-1:0]    byte_cnt_ff [qrm_pkg::RESOURCE_MONITOR_IDENTIFIER_CNT];
   logic [qrm_pkg::RESOURCE_MONITOR_IDENTIFIER_CNT-1:0]      seen_ff;
   logic [qrm_pkg::IRQ_W-1:0]         irq_stat_ff;
   logic [qrm_pkg::IRQ_W-1:0]         irq_en_ff;
   logic                              irq_ff;
   logic [qrm_pkg::DATA_W-1:0]        rdata_ff;

   logic                              hit_sel;
   logic                              hit_ctr;
   logic                              hit_assoc;
   logic                              hit_stat;
   logic                              hit_clr;
   logic                              hit_en;
   logic                              in_rsvd;
   logic                              unmapped;
   logic                              wr_resource_monitor_identifier_bad;
   logic                              wr_evt_bad;
   logic [qrm_pkg::CTR_DATA_W-1:0]    op_cnt_sel;
   logic [qrm_pkg::CTR_DATA_W-1:0]    op_cnt_cur;
   logic [qrm_pkg::CTR_DATA_W-1:0]    sel_data;
   logic                              sel_unav;
   logic [qrm_pkg::IRQ_W-1:0]         irq_set;
   logic [qrm_pkg::IRQ_W-1:0]         nxt_irq_stat;
   logic [qrm_pkg::DATA_W-1:0]        nxt_rdata;

   // ----------------------------------------------------------------
   // capability strap synchroniser
   // ----------------------------------------------------------------
   always_ff @(posedge i_mclk) begin
      if (i_reset) begin
         cap_meta_ff <= 1'b0;
         cap_ff      <= 1'b0;
      end else begin
         cap_meta_ff <= i_cap_strap;
         cap_ff      <= cap_meta_ff;
      end
   end

   // ----------------------------------------------------------------
   // address decode
   // ----------------------------------------------------------------
   // monitor registers vanish without the capability
   assign hit_sel   = cap_ff && (i_addr == qrm_pkg::ADDR_EVT_SEL);  // R1
   assign hit_ctr   = cap_ff && (i_addr == qrm_pkg::ADDR_CTR);      // R1
   assign hit_assoc = cap_ff && (i_addr == qrm_pkg::ADDR_ASSOC);    // R1
   assign hit_stat  = (i_addr == qrm_pkg::ADDR_IRQ_STAT);
   assign hit_clr   = (i_addr == qrm_pkg::ADDR_IRQ_CLR);
   assign hit_en    = (i_addr == qrm_pkg::ADDR_IRQ_EN);
   // whole reserved window decodes to nothing
   assign in_rsvd   = (i_addr >= qrm_pkg::RSVD_LO) && (i_addr <= qrm_pkg::RSVD_HI);  // R7
   assign unmapped  = !(hit_sel || hit_ctr || hit_assoc || hit_stat || hit_clr || hit_en)
                      && !in_rsvd;

   // checks on a select write: identifier above max or unknown event
   assign wr_resource_monitor_identifier_bad = (i_wdata[qrm_pkg::DATA_W-1:qrm_pkg::RESOURCE_MONITOR_IDENTIFIER_LSB] >
                         qrm_pkg::RESOURCE_MONITOR_IDENTIFIER_MAX);                                  // R5
   assign wr_evt_bad  = (i_wdata[qrm_pkg::EVT_LSB +: qrm_pkg::EVT_W] != qrm_pkg::EVT_OP_COUNT)
                     && (i_wdata[qrm_pkg::EVT_LSB +: qrm_pkg::EVT_W] != qrm_pkg::EVT_BYTE_COUNT);

   // ----------------------------------------------------------------
   // event select register
   // ----------------------------------------------------------------
   always_ff @(posedge i_mclk) begin
      if (i_reset) begin
         sel_evt_ff  <= qrm_pkg::EVT_RESET;
         sel_resource_monitor_identifier_ff <= '0;
         sel_err_ff  <= 1'b0;
      end else if (i_wr && hit_sel) begin
         sel_evt_ff  <= i_wdata[qrm_pkg::EVT_LSB +: qrm_pkg::EVT_W];        // R2
         sel_resource_monitor_identifier_ff <= i_wdata[qrm_pkg::RESOURCE_MONITOR_IDENTIFIER_LSB +: qrm_pkg::RESOURCE_MONITOR_IDENTIFIER_W];      // R3
         sel_err_ff  <= wr_resource_monitor_identifier_bad || wr_evt_bad;                          // R5
      end
   end

   // ----------------------------------------------------------------
   // association register, tags every internal operation
   // ----------------------------------------------------------------
   always_ff @(posedge i_mclk) begin
      if (i_reset) begin
         assoc_ff <= '0;
      end else if (i_wr && hit_assoc) begin
         assoc_ff <= i_wdata[qrm_pkg::RESOURCE_MONITOR_IDENTIFIER_W-1:0];  // R6
      end
   end

   // ----------------------------------------------------------------
   // per-identifier operation and byte counters
   // ----------------------------------------------------------------
   always_ff @(posedge i_mclk) begin
      if (i_reset) begin
         for (int r = 0; r < qrm_pkg::RESOURCE_MONITOR_IDENTIFIER_CNT; r++) begin
            op_cnt_ff[r]   <= '0;
            byte_cnt_ff[r] <= '0;
         end
         seen_ff <= '0;
      end else if (i_op_valid) begin
         // charge the operation to the associated identifier
         op_cnt_ff[assoc_ff]   <= op_cnt_ff[assoc_ff] + qrm_pkg::CTR_ONE;  // R6
         byte_cnt_ff[assoc_ff] <= byte_cnt_ff[assoc_ff]
            + {{(qrm_pkg::CTR_DATA_W-qrm_pkg::OP_BYTES_W){1'b0}}, i_op_bytes};
         seen_ff[assoc_ff]     <= 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // counter register value, from current selection
   // ----------------------------------------------------------------
   assign op_cnt_sel = op_cnt_ff[sel_resource_monitor_identifier_ff];
   assign op_cnt_cur = op_cnt_ff[assoc_ff];
   // event picks the counter, identifier picks the entry
   assign sel_data = sel_err_ff ? '0 :
                     (sel_evt_ff == qrm_pkg::EVT_OP_COUNT) ? op_cnt_sel :
                     byte_cnt_ff[sel_resource_monitor_identifier_ff];                            // R2 R3
   assign sel_unav = sel_err_ff || !seen_ff[sel_resource_monitor_identifier_ff];                 // R4

   // ----------------------------------------------------------------
   // interrupt status, clear and enable
   // ----------------------------------------------------------------
   assign irq_set[qrm_pkg::IRQ_SEL_ERR] = i_wr && hit_sel && (wr_resource_monitor_identifier_bad || wr_evt_bad);
   assign irq_set[qrm_pkg::IRQ_RSVD]    = (i_wr || i_rd) && in_rsvd;
   assign irq_set[qrm_pkg::IRQ_UNMAP]   = (i_wr || i_rd) && unmapped;
   // a new event wins over a clear in the same cycle
   assign nxt_irq_stat = (irq_stat_ff & ~((i_wr && hit_clr) ?
                          i_wdata[qrm_pkg::IRQ_W-1:0] : '0)) | irq_set;

   always_ff @(posedge i_mclk) begin
      if (i_reset) begin
         irq_stat_ff <= '0;
         irq_en_ff   <= '0;
         irq_ff      <= 1'b0;
      end else begin
         irq_stat_ff <= nxt_irq_stat;
         if (i_wr && hit_en) begin
            irq_en_ff <= i_wdata[qrm_pkg::IRQ_W-1:0];
         end
         irq_ff <= |(irq_stat_ff & irq_en_ff);
      end
   end

   // ----------------------------------------------------------------
   // read data, one cycle after the strobe
   // ----------------------------------------------------------------
   always_comb begin
      nxt_rdata = '0;
      if (i_rd) begin
         if (hit_sel) begin
            nxt_rdata[qrm_pkg::EVT_LSB +: qrm_pkg::EVT_W]   = sel_evt_ff;   // R2
            nxt_rdata[qrm_pkg::RESOURCE_MONITOR_IDENTIFIER_LSB +: qrm_pkg::RESOURCE_MONITOR_IDENTIFIER_W] = sel_resource_monitor_identifier_ff;  // R3
         end else if (hit_ctr) begin
            // live selection, so a read right after a select write is current
            nxt_rdata = {sel_err_ff, sel_unav, sel_data};                 // R4 R5 R8
         end else if (hit_assoc) begin
            nxt_rdata[qrm_pkg::RESOURCE_MONITOR_IDENTIFIER_W-1:0] = assoc_ff;                     // R6
         end else if (hit_stat) begin
            nxt_rdata[qrm_pkg::IRQ_W-1:0] = irq_stat_ff;
         end else if (hit_en) begin
            nxt_rdata[qrm_pkg::IRQ_W-1:0] = irq_en_ff;
         end
      end
   end

   always_ff @(posedge i_mclk) begin
      if (i_reset) begin
         rdata_ff <= '0;
      end else begin
         rdata_ff <= nxt_rdata;
      end
   end

   assign o_rdata   = rdata_ff;
   assign o_op_resource_monitor_identifier = assoc_ff;
   assign o_irq     = irq_ff;

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking chk_clk @(posedge i_mclk); endclocking
   default disable iff (i_reset);

   chk_cap_gate_read: assert property (  // R1
      (i_rd && !cap_ff && (i_addr == qrm_pkg::ADDR_CTR)) |=> (o_rdata == '0))
      else $error("counter answered without capability");

   chk_evt_field_read: assert property (  // R2
      (i_wr && hit_sel) ##1 (i_rd && hit_sel && !i_wr)
      |=> (o_rdata[qrm_pkg::EVT_LSB +: qrm_pkg::EVT_W]
           == $past(i_wdata[qrm_pkg::EVT_LSB +: qrm_pkg::EVT_W], 2)))
      else $error("event field not read back");

   chk_resource_monitor_identifier_field_read: assert property (  // R3
      (i_rd && hit_sel) |=> (o_rdata[qrm_pkg::RESOURCE_MONITOR_IDENTIFIER_LSB +: qrm_pkg::RESOURCE_MONITOR_IDENTIFIER_W]
                             == $past(sel_resource_monitor_identifier_ff)))
      else $error("identifier field wrong on read");

   chk_unav_flag: assert property (  // R4
      (i_rd && hit_ctr && !seen_ff[sel_resource_monitor_identifier_ff]) |=> o_rdata[qrm_pkg::CTR_UNAV])
      else $error("unavailable flag missing");

   chk_err_flag: assert property (  // R5
      (i_wr && hit_sel && wr_evt_bad) ##1 (i_rd && hit_ctr)
      |=> (o_rdata[qrm_pkg::CTR_ERR] && o_rdata[qrm_pkg::CTR_UNAV]))
      else $error("error flag missing after bad select");

   chk_assoc_count: assert property (  // R6
      i_op_valid |=> (op_cnt_ff[$past(assoc_ff)] == $past(op_cnt_cur) + qrm_pkg::CTR_ONE))
      else $error("tagged operation not counted");

   chk_rsvd_silent: assert property (  // R7
      (i_rd && in_rsvd) |=> ((o_rdata == '0) && irq_stat_ff[qrm_pkg::IRQ_RSVD]))
      else $error("reserved address answered");

   chk_sel_then_read: assert property (  // R8
      (i_wr && hit_sel && !wr_evt_bad && !wr_resource_monitor_identifier_bad
       && (i_wdata[qrm_pkg::EVT_LSB +: qrm_pkg::EVT_W] == qrm_pkg::EVT_OP_COUNT))
      ##1 (i_rd && hit_ctr && seen_ff[sel_resource_monitor_identifier_ff])
      |=> (!o_rdata[qrm_pkg::CTR_ERR]
           && (o_rdata[qrm_pkg::CTR_DATA_W-1:0] == $past(op_cnt_sel))))
      else $error("counter stale after select write");

   chk_irq_level: assert property (
      (|(irq_stat_ff & irq_en_ff)) |=> o_irq)
      else $error("interrupt not raised");

   // the unmapped status bit only drops on a clear write that names it
   chk_stat_sticky: assert property (
      (irq_stat_ff[qrm_pkg::IRQ_UNMAP]
       && !(i_wr && hit_clr && i_wdata[qrm_pkg::IRQ_UNMAP]))
      |=> irq_stat_ff[qrm_pkg::IRQ_UNMAP])
      else $error("status bit lost without clear");

   cov_sel_read: cover property ((i_wr && hit_sel) ##1 (i_rd && hit_ctr));
   cov_rsvd: cover property (i_rd && in_rsvd);
   cov_irq: cover property ($rose(o_irq));
   cov_op_count: cover property (i_op_valid ##1 i_op_valid);
endmodule
`default_nettype wire

//--- qrm_monitor_tb.sv
// qrm_monitor_tb: self-checking bench for the resource monitor register block
// assumes: qrm_pkg and qrm_monitor compiled first; one 40 MHz clock, sync reset
`timescale 1ns/1ps
`default_nettype none
module qrm_monitor_tb;
   // ----------------------------------------------------------------
   // design signals and reference model state
   // ----------------------------------------------------------------
   logic                               i_mclk;
   logic                               i_reset;
   logic                               i_cap_strap;
   logic [qrm_pkg::ADDR_W-1:0]         i_addr;
   logic [qrm_pkg::DATA_W-1:0]         i_wdata;
   logic                               i_wr;
   logic                               i_rd;
   logic                               i_op_valid;
   logic [qrm_pkg::OP_BYTES_W-1:0]     i_op_bytes;
   logic [qrm_pkg::DATA_W-1:0]         o_rdata;
   logic [qrm_pkg::RESOURCE_MONITOR_IDENTIFIER_W-1:0]         o_op_resource_monitor_identifier;
   logic                               o_irq;
   logic [61:0]                        op_cnt [qrm_pkg::RESOURCE_MONITOR_IDENTIFIER_CNT];
   logic [61:0]                        byt_cnt [qrm_pkg::RESOURCE_MONITOR_IDENTIFIER_CNT];
   logic                               seen [qrm_pkg::RESOURCE_MONITOR_IDENTIFIER_CNT];
   logic [31:0]                        seed;
   int                                 cur_rm;
   int                                 err_count;
   int                                 comparisons;

   qrm_monitor u_qrm_monitor (
      .i_mclk      (i_mclk),
      .i_reset     (i_reset),
      .i_cap_strap (i_cap_strap),
      .i_addr      (i_addr),
      .i_wdata     (i_wdata),
      .i_wr        (i_wr),
      .i_rd        (i_rd),
      .i_op_valid  (i_op_valid),
      .i_op_bytes  (i_op_bytes),
      .o_rdata     (o_rdata),
      .o_op_resource_monitor_identifier   (o_op_resource_monitor_identifier),
      .o_irq       (o_irq)
   );

   // ----------------------------------------------------------------
   // clock, watchdog and helpers
   // ----------------------------------------------------------------
   // 25 ns period
   initial begin
      i_mclk = 1'b0;
      forever #12.5 i_mclk = ~i_mclk;
   end

   // hang guard, far beyond the 158 cycles the run needs
   initial begin
      repeat (20000) @(posedge i_mclk);
      err_count++;
      end_of_test();
   end

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      lfsr = {1'b0, s[31:1]} ^ (s[0] ? 32'h8020_0003 : 32'h0);
   endfunction

   // counter word the rules predict for an event and identifier
   function automatic logic [63:0] exp_ctr(input logic [7:0] ev, input int rm);
      exp_ctr = {1'b0, ~seen[rm], (ev == qrm_pkg::EVT_OP_COUNT) ? op_cnt[rm] : byt_cnt[rm]};
   endfunction

   task automatic check(input logic [63:0] seen_v, input logic [63:0] exp_v);
      comparisons++;
      if (seen_v !== exp_v) begin
         err_count++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen_v, exp_v);
      end
   endtask

   // every driver task sets each strobe once, right after an edge; rd also clears i_rd after its first edge
   task automatic strobes(input logic w, input logic r, input logic v);
      i_wr       <= w;
      i_rd       <= r;
      i_op_valid <= v;
   endtask

   task automatic wr(input logic [31:0] a, input logic [63:0] d);
      strobes(1'b1, 1'b0, 1'b0);
      i_addr  <= a;
      i_wdata <= d;
      @(posedge i_mclk);
   endtask

   // read, then compare in the single cycle the data stands
   task automatic rd(input logic [31:0] a, input logic [63:0] exp_v);
      strobes(1'b0, 1'b1, 1'b0);
      i_addr <= a;
      @(posedge i_mclk);
      i_rd <= 1'b0;
      @(negedge i_mclk);
      check(o_rdata, exp_v);
      @(posedge i_mclk);
   endtask

   task automatic op(input logic [7:0] b);
      strobes(1'b0, 1'b0, 1'b1);
      i_op_bytes <= b;
      @(posedge i_mclk);
      op_cnt[cur_rm]  = op_cnt[cur_rm] + 62'h1;
      byt_cnt[cur_rm] = byt_cnt[cur_rm] + 62'(b);
      seen[cur_rm]    = 1'b1;
   endtask

   task automatic idle(input int n);
      strobes(1'b0, 1'b0, 1'b0);
      repeat (n) @(posedge i_mclk);
   endtask

   task automatic chk_irq(input logic exp_v);
      idle(2);
      @(negedge i_mclk);
      check(64'(o_irq), 64'(exp_v));
      @(posedge i_mclk);
   endtask

   task automatic end_of_test();
      $display("comparisons %0d err_count %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      i_reset = 1'b1;
      i_cap_strap = 1'b0;
      i_addr = '0;
      i_wdata = '0;
      i_wr = 1'b0;
      i_rd = 1'b0;
      i_op_valid = 1'b0;
      i_op_bytes = '0;
      seed = 32'hDBEF_A65C;
      cur_rm = 0;
      err_count = 0;
      comparisons = 0;
      for (int k = 0; k < 4; k++) begin
         op_cnt[k] = '0;
         byt_cnt[k] = '0;
         seen[k] = 1'b0;
      end
      repeat (5) @(posedge i_mclk);
      i_reset <= 1'b0;
      @(posedge i_mclk);
      // capability low: registers absent, access flagged unmapped, irq masked
      wr(qrm_pkg::ADDR_EVT_SEL, 64'h0000_0001_0000_0001);
      rd(qrm_pkg::ADDR_EVT_SEL, 64'h0);
      rd(qrm_pkg::ADDR_CTR, 64'h0);
      rd(qrm_pkg::ADDR_IRQ_STAT, 64'h4);
      chk_irq(1'b0);
      wr(qrm_pkg::ADDR_IRQ_EN, 64'h7);
      rd(qrm_pkg::ADDR_IRQ_EN, 64'h7);
      chk_irq(1'b1);
      wr(qrm_pkg::ADDR_IRQ_CLR, 64'h7);
      chk_irq(1'b0);
      rd(qrm_pkg::ADDR_IRQ_STAT, 64'h0);
      // capability raised: select keeps only its fields, counter follows at once
      i_cap_strap <= 1'b1;
      idle(3);
      rd(qrm_pkg::ADDR_EVT_SEL, 64'h0);
      wr(qrm_pkg::ADDR_EVT_SEL, 64'h0000_0003_FFFF_FF02);
      rd(qrm_pkg::ADDR_EVT_SEL, 64'h0000_0003_0000_0002);
      rd(qrm_pkg::ADDR_CTR, 64'h4000_0000_0000_0000);
      wr(qrm_pkg::ADDR_ASSOC, 64'hFFFF_FFFF_FFFF_FFFE);
      cur_rm = 2;
      rd(qrm_pkg::ADDR_ASSOC, 64'h2);
      check(64'(o_op_resource_monitor_identifier), 64'h2);
      // random operations with occasional re-association
      for (int n = 0; n < 60; n++) begin
         seed = lfsr(seed);
         if (seed[2:0] == 3'h0) begin
            wr(qrm_pkg::ADDR_ASSOC, {62'h0, seed[9:8]});
            cur_rm = int'(seed[9:8]);
         end else begin
            op(seed[17:10]);
         end
      end
      idle(1);
      check(64'(o_op_resource_monitor_identifier), 64'(cur_rm));
      op(8'hFF);
      wr(qrm_pkg::ADDR_CTR, 64'hFFFF_FFFF_FFFF_FFFF);
      // every identifier and event, read straight after selecting
      for (int rm = 0; rm < 4; rm++) begin
         for (int e = 1; e <= 2; e++) begin
            wr(qrm_pkg::ADDR_EVT_SEL, (64'(rm) << 32) | 64'(e));
            rd(qrm_pkg::ADDR_CTR, exp_ctr(8'(e), rm));
         end
      end
      // unsupported event codes and identifiers
      wr(qrm_pkg::ADDR_IRQ_CLR, 64'h7);
      wr(qrm_pkg::ADDR_EVT_SEL, 64'h0000_0000_0000_0003);
      rd(qrm_pkg::ADDR_CTR, 64'hC000_0000_0000_0000);
      wr(qrm_pkg::ADDR_EVT_SEL, 64'h0000_0004_0000_0001);
      rd(qrm_pkg::ADDR_CTR, 64'hC000_0000_0000_0000);
      wr(qrm_pkg::ADDR_EVT_SEL, 64'h0000_0000_0000_0000);
      rd(qrm_pkg::ADDR_CTR, 64'hC000_0000_0000_0000);
      rd(qrm_pkg::ADDR_IRQ_STAT, 64'h1);
      chk_irq(1'b1);
      wr(qrm_pkg::ADDR_EVT_SEL, 64'h0000_0001_0000_0001);
      rd(qrm_pkg::ADDR_CTR, exp_ctr(8'h01, 1));
      // reserved address range and its edges
      wr(qrm_pkg::ADDR_IRQ_CLR, 64'h7);
      rd(qrm_pkg::RSVD_LO, 64'h0);
      rd(qrm_pkg::RSVD_HI, 64'h0);
      wr(32'h4000_0080, 64'hFFFF_FFFF_FFFF_FFFF);
      rd(qrm_pkg::ADDR_IRQ_STAT, 64'h2);
      rd(32'h4000_0100, 64'h0);
      rd(qrm_pkg::ADDR_IRQ_STAT, 64'h6);
      end_of_test();
   end
endmodule
`default_nettype wire
